// ---- shared/tsc_pkg.sv ----
package tsc_pkg;
  // Clock and millisecond tick
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  // Timer width in bits; timers count milliseconds
  localparam int TMR_W = 10;
  // Nominal times in milliseconds
  localparam logic [TMR_W-1:0] LEAD_DELAY_MS   = 10'h014; // 20 ms
  localparam logic [TMR_W-1:0] MIN_BREAK_MS    = 10'h032; // 50 ms
  localparam logic [TMR_W-1:0] SEIZE_CUT_MS    = 10'h07D; // 125 ms
  localparam logic [TMR_W-1:0] DISC_CUT_MS     = 10'h271; // 625 ms
  localparam logic [TMR_W-1:0] RCV_DIAL_CUT_MS = 10'h271; // 625 ms
  localparam logic [TMR_W-1:0] NOTCH_IN_MS     = 10'h00D; // 13 ms
  localparam logic [TMR_W-1:0] NOTCH_OUT_MS    = 10'h032; // 50 ms
  localparam logic [TMR_W-1:0] HIGH_LEVEL_MS   = 10'h190; // 400 ms
  // Reset values: idle circuit sends tone, path cut, notch inserted
  localparam logic RST_TONE  = 1'b1;
  localparam logic RST_CUT   = 1'b1;
  localparam logic RST_NOTCH = 1'b1;
  localparam logic RST_RCV   = 1'b1;
endpackage

// ---- rtl/tsc_ms_timer.sv ----
`timescale 1ns/1ns
module tsc_ms_timer
  import tsc_pkg::*;
#(
  parameter int W = TMR_W
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic         tick_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_ms_in,
  output logic              running_out,
  output logic              done_out
);
  initial begin
    if (W < 2) $error("tsc_ms_timer: W too small");
  end

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // Load wins, else count down one per tick
  always_comb begin
    count_next = count_reg;
    if (load_in) begin
      count_next = load_ms_in;
    end else if (tick_in && count_reg != '0) begin
      count_next = count_reg - W'(1);
    end
  end

  // Counter and flags
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg   <= '0;
      running_out <= 1'b0;
      done_out    <= 1'b0;
    end else begin
      count_reg   <= count_next;
      running_out <= count_next != '0;
      done_out    <= !load_in && tick_in && count_reg == W'(1);
    end
  end

  a_tick_paced: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !load_in && !tick_in |=> count_reg == $past(count_reg))
    else $error("timer moved without a tick");
endmodule // tsc_ms_timer

// ---- rtl/tsc_tone_xmt_ctrl.sv ----
// How it works
// - Outgoing lead delayed 20 ms, glitches ignored
// - Tone intervals stretched to 50 ms in calls
// - Intervals above 50 ms pass unchanged
// - No stretch outside a call; winks kept
// - Path cut when idle, closed when busy
// - Path cut during dialing either direction
// - Brief cut on lead change at chosen state
// - Seizure keeps path cut 125 ms
// - Notch removed 50 ms after tone stops
// - Notch inserted 13 ms after tone arrives
// - Dial precut; cut 125 ms past last edge
// - Local disconnect precut, lasting cut at 625
// - Tone polarity per normal or inverted mode
// - High tone level in dialing, first 400 ms
`timescale 1ns/1ns
module tsc_tone_xmt_ctrl
  import tsc_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic lead_battery_in,
  input  wire logic lead_ground_in,
  input  wire logic invert_mode_in,
  input  wire logic rcv_tone_in,
  input  wire logic cut_rcv_state_in,
  output logic      tone_on_out,
  output logic      tone_high_out,
  output logic      xmt_cut_out,
  output logic      notch_insert_out
);
  initial begin
    if (TICK_CNT < 2) $error("tsc_tone_xmt_ctrl: TICK_CNT below 2");
  end

  logic [31:0]      tick_cnt_reg;
  logic             tick_reg;
  logic             raw_tone;
  logic             raw_prev_reg;
  logic             raw_edge;
  logic             filt_reg;
  logic [TMR_W-1:0] filt_cnt_reg;
  logic             filt_upd;
  logic             filt_on;
  logic             filt_off;
  logic             tone_reg;
  logic             pend_off_reg;
  logic             seized_reg;
  logic             rcv_prev_reg;
  logic             rcv_rise;
  logic             rcv_fall;
  logic             dialing;
  logic             mb_run, mb_done;
  logic             hi_run;
  logic             hold_run;
  logic             disc_run, disc_done;
  logic             rwin_run;
  logic             rcut_run;
  logic             notch_done;
  logic             hold_load;
  logic [TMR_W-1:0] notch_ms;

  // Single 1 ms tick from the system clock
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 32'(TICK_CNT - 1)) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      tick_reg     <= 1'b0;
    end
  end

  // Tick phase against a load gives N-1 to N ms per timer;
  // every tolerance on the cut and notch times absorbs that
  a_tick_single: assert property (@(posedge clk_in) disable iff (!resetn_in)
    tick_reg |=> !tick_reg)
    else $error("tick longer than one cycle");

  // Tone request from lead state and polarity mode
  assign raw_tone = invert_mode_in ? !lead_ground_in : !lead_battery_in;
  assign raw_edge = raw_tone != raw_prev_reg;

  // Symmetric delay: new lead state must hold for the full delay
  assign filt_upd = tick_reg && raw_tone != filt_reg
                    && filt_cnt_reg == LEAD_DELAY_MS - TMR_W'(1);
  assign filt_on  = filt_upd && raw_tone;
  assign filt_off = filt_upd && !raw_tone;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      filt_reg     <= RST_TONE;
      filt_cnt_reg <= '0;
      raw_prev_reg <= RST_TONE;
    end else begin
      raw_prev_reg <= raw_tone;
      if (raw_tone == filt_reg) begin
        filt_cnt_reg <= '0;
      end else if (filt_upd) begin
        filt_reg     <= raw_tone;
        filt_cnt_reg <= '0;
      end else if (tick_reg) begin
        filt_cnt_reg <= filt_cnt_reg + TMR_W'(1);
      end
    end
  end

  // Tone gate with minimum-break stretch during a call
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tone_reg     <= RST_TONE;
      pend_off_reg <= 1'b0;
    end else if (filt_on) begin
      tone_reg     <= 1'b1;
      pend_off_reg <= 1'b0;
    end else if (filt_off) begin
      if (seized_reg && mb_run) begin
        pend_off_reg <= 1'b1;
      end else begin
        tone_reg <= 1'b0;
      end
    end else if (pend_off_reg && mb_done) begin
      tone_reg     <= 1'b0;
      pend_off_reg <= 1'b0;
    end
  end

  // Tone moves only on a delayed lead change or a stretch end
  a_tone_by_filter: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $changed(tone_reg) |-> $past(filt_upd || (pend_off_reg && mb_done)))
    else $error("tone moved without a lead change");

  // A held break exists only inside a call
  a_stretch_in_call: assert property (@(posedge clk_in) disable iff (!resetn_in)
    pend_off_reg |-> seized_reg)
    else $error("break stretched outside a call");

  // Intervals past the minimum end with the lead
  a_long_unchanged: assert property (@(posedge clk_in) disable iff (!resetn_in)
    filt_off && !mb_run |=> !tone_reg)
    else $error("long tone interval was altered");

  // Call state: seized on tone stop, released after disconnect cut
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seized_reg <= 1'b0;
    end else if (!seized_reg && filt_off) begin
      seized_reg <= 1'b1;
    end else if (disc_done && !filt_off) begin
      // A tone stop in the release cycle wins: the call carries on
      seized_reg <= 1'b0;
    end
  end

  // Receive tone edges
  assign rcv_rise = rcv_tone_in && !rcv_prev_reg;
  assign rcv_fall = !rcv_tone_in && rcv_prev_reg;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rcv_prev_reg <= RST_RCV;
    end else begin
      rcv_prev_reg <= rcv_tone_in;
    end
  end

  // Cut hold: seizure, dial edges, precut and chosen receive state
  // Lead edges in a call already reload the hold; the receive-state
  // term keeps the brief cut armed whatever the call state
  assign hold_load = (!seized_reg && filt_off)
                     || (seized_reg && (raw_edge || filt_upd))
                     || (raw_edge && rcv_tone_in == cut_rcv_state_in);
  assign dialing   = seized_reg && hold_run;
  assign notch_ms  = rcv_tone_in ? NOTCH_IN_MS : NOTCH_OUT_MS;

  tsc_ms_timer u_min_break (
    .clk_in (clk_in), .resetn_in (resetn_in), .tick_in (tick_reg),
    .load_in (filt_on), .load_ms_in (MIN_BREAK_MS),
    .running_out (mb_run), .done_out (mb_done)
  );
  tsc_ms_timer u_high_level (
    .clk_in (clk_in), .resetn_in (resetn_in), .tick_in (tick_reg),
    .load_in (filt_on), .load_ms_in (HIGH_LEVEL_MS),
    .running_out (hi_run), .done_out ()
  );
  tsc_ms_timer u_cut_hold (
    .clk_in (clk_in), .resetn_in (resetn_in), .tick_in (tick_reg),
    .load_in (hold_load), .load_ms_in (SEIZE_CUT_MS),
    .running_out (hold_run), .done_out ()
  );

  // Every hold request starts the cut timer
  a_hold_loaded: assert property (@(posedge clk_in) disable iff (!resetn_in)
    hold_load |=> hold_run)
    else $error("cut hold did not start");
  // Disconnect timer restarts on tone on, cancelled on tone off
  tsc_ms_timer u_disconnect (
    .clk_in (clk_in), .resetn_in (resetn_in), .tick_in (tick_reg),
    .load_in (seized_reg && filt_upd),
    .load_ms_in (filt_on ? DISC_CUT_MS : TMR_W'(0)),
    .running_out (disc_run), .done_out (disc_done)
  );

  // Disconnect timing runs only while a call stands
  a_disc_in_call: assert property (@(posedge clk_in) disable iff (!resetn_in)
    disc_run |-> seized_reg)
    else $error("disconnect timer outside a call");
  // Distant dialing: a tone return soon after a break is a pulse
  tsc_ms_timer u_rcv_window (
    .clk_in (clk_in), .resetn_in (resetn_in), .tick_in (tick_reg),
    .load_in (rcv_fall), .load_ms_in (RCV_DIAL_CUT_MS),
    .running_out (rwin_run), .done_out ()
  );
  tsc_ms_timer u_rcv_cut (
    .clk_in (clk_in), .resetn_in (resetn_in), .tick_in (tick_reg),
    .load_in (rcv_rise && rwin_run), .load_ms_in (RCV_DIAL_CUT_MS),
    .running_out (rcut_run), .done_out ()
  );

  // Distant dialing cut starts only inside the receive window
  a_rcv_cut_window: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(rcut_run) |-> $past(rwin_run))
    else $error("distant dial cut without window");
  tsc_ms_timer u_notch (
    .clk_in (clk_in), .resetn_in (resetn_in), .tick_in (tick_reg),
    .load_in (rcv_rise || rcv_fall), .load_ms_in (notch_ms),
    .running_out (), .done_out (notch_done)
  );

  // Registered outputs
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tone_on_out   <= RST_TONE;
      tone_high_out <= 1'b0;
      xmt_cut_out   <= RST_CUT;
    end else begin
      tone_on_out   <= tone_reg;
      tone_high_out <= tone_reg && (hi_run || dialing);
      xmt_cut_out   <= !seized_reg || hold_run || rcut_run;
    end
  end

  // Busy with no timer running closes the path
  a_busy_path_open: assert property (@(posedge clk_in) disable iff (!resetn_in)
    seized_reg && !hold_run && !rcut_run |=> !xmt_cut_out)
    else $error("path cut while busy");

  // Each tone application starts at the raised level
  a_high_first_part: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(tone_reg) |-> hi_run)
    else $error("tone start not at high level");

  // Notch follows receive tone after the insert or remove delay
  // No minimum insertion time after distant dialing is kept here
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      notch_insert_out <= RST_NOTCH;
    end else if (notch_done) begin
      notch_insert_out <= rcv_prev_reg;
    end
  end

  a_idle_path_cut: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !seized_reg |=> xmt_cut_out)
    else $error("path not cut while idle");
  a_seize_hold_cut: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(seized_reg) |-> hold_run ##1 xmt_cut_out)
    else $error("seizure did not hold cut");
  a_lead_delay_only: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $changed(filt_reg) |-> $past(tick_reg) && $past(raw_tone) == filt_reg)
    else $error("lead changed without full delay");
  a_break_min_len: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $fell(tone_reg) && $past(seized_reg) |-> !$past(mb_run))
    else $error("tone break ended under minimum");
  a_no_stretch_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !seized_reg && filt_off |=> !tone_reg)
    else $error("tone stretched outside a call");
  a_lead_polarity: assert property (@(posedge clk_in) disable iff (!resetn_in)
    filt_upd |=> filt_reg == ($past(invert_mode_in) ? !$past(lead_ground_in)
                                                    : !$past(lead_battery_in)))
    else $error("tone polarity wrong for mode");
  a_notch_follow: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $changed(notch_insert_out) |-> $past(notch_done) && notch_insert_out == $past(rcv_prev_reg))
    else $error("notch changed without its delay");
  a_dial_precut: assert property (@(posedge clk_in) disable iff (!resetn_in)
    seized_reg && raw_edge |=> hold_run ##1 xmt_cut_out)
    else $error("lead edge gave no precut");
  a_disc_release: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $fell(seized_reg) |-> $past(disc_done) && tone_reg)
    else $error("release without disconnect time");
  a_dial_high: assert property (@(posedge clk_in) disable iff (!resetn_in)
    tone_reg && dialing |=> tone_high_out)
    else $error("dial tone not at high level");
  a_rcv_dial_cut: assert property (@(posedge clk_in) disable iff (!resetn_in)
    rcut_run |=> xmt_cut_out)
    else $error("path not cut in distant dialing");
endmodule // tsc_tone_xmt_ctrl

// ---- tb/tsc_trunk_model.sv ----
`timescale 1ns/1ns
// Trunk side: outgoing lead states and qualified facility tone
module tsc_trunk_model (
  input  wire logic [1:0] lead_sel_in,
  input  wire logic       rcv_req_in,
  output logic            lead_battery_out,
  output logic            lead_ground_out,
  output logic            rcv_tone_out
);
  // Lead select: 0 open, 1 battery, 2 ground; never both at once
  assign lead_battery_out = (lead_sel_in == 2'h1);
  assign lead_ground_out  = (lead_sel_in == 2'h2);
  // Received tone, already qualified by the detector
  assign rcv_tone_out = rcv_req_in;
endmodule // tsc_trunk_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  import tsc_pkg::*;
  localparam int TICK = 4;
  logic       clk_in;
  logic       resetn_in;
  logic [1:0] lead_sel;
  logic       rcv_req;
  logic       invert_mode;
  logic       cut_rcv_state;
  logic       lead_battery;
  logic       lead_ground;
  logic       rcv_tone;
  logic       tone_on;
  logic       tone_high;
  logic       xmt_cut;
  logic       notch;
  int         n_fail;
  int         checked;
  logic [15:0] seed;
  logic       m_filt;
  logic       m_hist[$];

  // Far side of the block
  tsc_trunk_model trunk (.lead_sel_in(lead_sel), .rcv_req_in(rcv_req),
    .lead_battery_out(lead_battery), .lead_ground_out(lead_ground), .rcv_tone_out(rcv_tone));

  tsc_tone_xmt_ctrl #(.TICK_CNT(TICK)) dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .lead_battery_in(lead_battery), .lead_ground_in(lead_ground),
    .invert_mode_in(invert_mode), .rcv_tone_in(rcv_tone),
    .cut_rcv_state_in(cut_rcv_state), .tone_on_out(tone_on), .tone_high_out(tone_high),
    .xmt_cut_out(xmt_cut), .notch_insert_out(notch));

  // Clock
  always #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;

  // Reference for the raw tone state of a lead
  function automatic logic exp_tone(input int sel, input logic inv);
    return inv ? (sel != 2) : (sel != 1);
  endfunction

  // Model of the lead delay: a state counts once it fills the window
  function automatic void model_step();
    int same;
    same = 0;
    m_hist.push_back(exp_tone(lead_sel, invert_mode));
    if (m_hist.size() > int'(LEAD_DELAY_MS)) begin
      void'(m_hist.pop_front());
    end
    foreach (m_hist[i]) begin
      if (m_hist[i] == m_hist[0]) begin
        same++;
      end
    end
    if (same == int'(LEAD_DELAY_MS)) begin
      m_filt = m_hist[0];
    end
  endfunction

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string name, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", name, exp, seen);
    end
  endtask

  // Wait whole milliseconds, ending on a falling edge; model steps each one
  task automatic ms(input int n);
    repeat (n) begin
      repeat (TICK) @(negedge clk_in);
      model_step();
    end
  endtask

  task automatic results;
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog at twice the planned run of about 3 s
  initial begin
    #(CLK_PERIOD_NS * 6000 * TICK);
    n_fail++;
    results();
  end

  // Main sequence
  initial begin
    clk_in = 1'b0;
    resetn_in = 1'b0;
    lead_sel = 2'h0;
    rcv_req = 1'b1;
    invert_mode = 1'b0;
    cut_rcv_state = 1'b0;
    n_fail = 0;
    checked = 0;
    seed = 16'h0010;
    m_filt = 1'b1;
    repeat (5) @(negedge clk_in);
    resetn_in = 1'b1;
    ms(2);
    check("tone idle", tone_on, m_filt);
    check("cut idle", xmt_cut, 1'b1);
    check("notch idle", notch, 1'b1);
    // Short random glitches must not stop the tone
    for (int i = 0; i < 4; i++) begin
      seed = lfsr_next(seed);
      lead_sel = 2'h1;
      ms(2 + int'(seed[7:4] % 16'h000C));
      lead_sel = 2'h0;
      ms(25);
      check("tone glitch", tone_on, m_filt);
    end
    // Seizure: tone stops after the lead delay, cut held about 125 ms
    lead_sel = 2'h1;
    ms(18);
    check("tone early", tone_on, m_filt);
    ms(5);
    check("tone seized", tone_on, m_filt);
    ms(90);
    check("cut seize hold", xmt_cut, 1'b1);
    check("notch seize", notch, 1'b1);
    ms(60);
    check("cut busy", xmt_cut, 1'b0);
    // Received tone stops, then returns inside the window
    rcv_req = 1'b0;
    ms(45);
    check("notch held", notch, 1'b1);
    ms(10);
    check("notch out", notch, 1'b0);
    rcv_req = 1'b1;
    ms(8);
    check("notch wait", notch, 1'b0);
    ms(10);
    check("notch in", notch, 1'b1);
    check("cut rcv dial", xmt_cut, 1'b1);
    ms(700);
    check("cut after rcv dial", xmt_cut, 1'b0);
    // Brief cut on lead edge at the chosen receive state
    cut_rcv_state = 1'b1;
    lead_sel = 2'h2;
    ms(5);
    lead_sel = 2'h1;
    ms(3);
    check("cut brief", xmt_cut, 1'b1);
    ms(200);
    check("cut brief end", xmt_cut, 1'b0);
    cut_rcv_state = 1'b0;
    // Dial pulse of 30 ms: precut, raised level, stretched to 50 ms
    lead_sel = 2'h0;
    ms(3);
    check("precut", xmt_cut, 1'b1);
    check("tone not yet", tone_on, m_filt);
    ms(22);
    check("tone pulse", tone_on, m_filt);
    check("tone high", tone_high, 1'b1);
    ms(5);
    lead_sel = 2'h1;
    ms(35);
    check("break stretched", tone_on, 1'b1);
    ms(10);
    check("break ends", tone_on, 1'b0);
    check("cut dial hold", xmt_cut, 1'b1);
    ms(200);
    check("cut dial end", xmt_cut, 1'b0);
    // Long tone interval of 80 ms passes unchanged
    lead_sel = 2'h0;
    ms(80);
    lead_sel = 2'h1;
    ms(15);
    check("long tone", tone_on, m_filt);
    ms(10);
    check("long tone end", tone_on, m_filt);
    ms(200);
    // Local disconnect: precut, then lasting cut near 625 ms
    lead_sel = 2'h0;
    ms(400);
    check("disc open path", xmt_cut, 1'b0);
    check("tone high start", tone_high, 1'b1);
    ms(300);
    check("disc cut", xmt_cut, 1'b1);
    check("tone high timeout", tone_high, 1'b0);
    ms(300);
    check("disc cut lasts", xmt_cut, 1'b1);
    // Inverted lead mode
    invert_mode = 1'b1;
    lead_sel = 2'h2;
    ms(25);
    check("inv ground", tone_on, m_filt);
    lead_sel = 2'h1;
    ms(25);
    check("inv battery", tone_on, m_filt);
    results();
  end
endmodule // testbench
